// file: hw/device_code_decoder.sv
// Device-code decoder for host request messages.
// Assumes a parsed request (frame, code or ASCII name, start, points) as a
// one-cycle valid pulse; verdict follows two cycles later.
// Requests may come every cycle; nothing stalls.
// What this block does
// - Code 9Ch: input area, hex 0..1FFF
// - Code 9Dh: output area, hex 0..1FFF
// - ASCII second character may be space
// - Code A8h: general registers 0..8191 or 19823
// - Only 3E frames accepted
// - Code E0h: motion registers 0..12287
// - Code 90h: internal relays 0..12287
// - Codes 91h/A9h: special areas 0..2255
// - 93h annunciator; A0h/B4h link areas
// - Start plus points beyond range: C056H
`timescale 1ns/1ps
module device_code_decoder
  import dev_code_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic req_valid_i,
  input wire dev_req_t req_i,
  input wire logic adv_sync_i,
  output logic rsp_valid_o,
  output dev_rsp_t rsp_o
);

  // ****************************************************************
  // Code decode functions
  // ****************************************************************
  // Binary codes; anything not listed decodes to no area
  function automatic area_t bin_area(input logic [7:0] code);
    area_t a;
    a = AREA_NONE;
    case (code)
      CODE_SPECIAL_RELAY: a = AREA_SPECIAL_RELAY;
      CODE_SPECIAL_REGISTER: a = AREA_SPECIAL_REGISTER;
      CODE_INPUT: a = AREA_INPUT;
      CODE_OUTPUT: a = AREA_OUTPUT;
      CODE_INTERNAL_RELAY: a = AREA_INTERNAL_RELAY;
      CODE_ANNUNCIATOR: a = AREA_ANNUNCIATOR;
      CODE_LINK_RELAY: a = AREA_LINK_RELAY;
      CODE_GENERAL_REGISTER: a = AREA_GENERAL_REGISTER;
      CODE_LINK_REGISTER: a = AREA_LINK_REGISTER;
      CODE_MOTION_REGISTER: a = AREA_MOTION_REGISTER;
      default: a = AREA_NONE;
    endcase
    return a;
  endfunction

  // Name is first character, then second character
  function automatic area_t ascii_area(input logic [15:0] name);
    area_t a;
    logic one_char;
    a = AREA_NONE;
    one_char = (name[7:0] == ASCII_SPACE);
    // Two-letter names must match in full
    if (name == ASC_SPECIAL_RELAY)
      a = AREA_SPECIAL_RELAY;
    else if (name == ASC_SPECIAL_REGISTER)
      a = AREA_SPECIAL_REGISTER;
    // One-letter names: the letter, then a space
    else if (one_char)
    begin
      case (name[15:8])
        ASC_INPUT: a = AREA_INPUT;
        ASC_OUTPUT: a = AREA_OUTPUT;
        ASC_INTERNAL_RELAY: a = AREA_INTERNAL_RELAY;
        ASC_ANNUNCIATOR: a = AREA_ANNUNCIATOR;
        ASC_LINK_RELAY: a = AREA_LINK_RELAY;
        ASC_GENERAL_REGISTER: a = AREA_GENERAL_REGISTER;
        ASC_LINK_REGISTER: a = AREA_LINK_REGISTER;
        ASC_MOTION_REGISTER: a = AREA_MOTION_REGISTER;
        default: a = AREA_NONE;
      endcase
    end
    return a;
  endfunction

  // ****************************************************************
  // Verdict helper functions
  // ****************************************************************

  // Only one frame format is served on this port
  function automatic logic frame_ok(input logic [1:0] frame);
    return frame == FRAME_3E;
  endfunction

  // One bit wider than the start number, so a large point count cannot
  // wrap round and slip under the limit
  function automatic logic over_range(
    input logic [23:0] first,
    input logic [15:0] count,
    input logic [23:0] last
  );
    logic [24:0] end_excl;
    logic [24:0] end_max;
    end_excl = {1'b0, first} + {9'h000, count};
    end_max = {1'b0, last} + 25'h0000001;
    return end_excl > end_max;
  endfunction

  // Error code by priority: frame first, then device code, then range;
  // a request with no area never reaches the range check
  function automatic logic [15:0] verdict(
    input logic frame_good,
    input area_t area,
    input logic too_far
  );
    logic [15:0] err;
    err = ERR_NONE;
    if (!frame_good)
      err = ERR_FRAME;
    else if (area == AREA_NONE)
      err = ERR_DEVICE;
    else if (too_far)
      err = ERR_RANGE;
    return err;
  endfunction

  // ****************************************************************
  // Stage 1: decode
  // ****************************************************************
  logic s1_valid_q;
  area_t s1_area_q;
  logic s1_frame_ok_q;
  logic [23:0] s1_start_q;
  logic [15:0] s1_points_q;
  area_t area_d;
  // Last valid number of the area, good in the cycle after a request
  logic [23:0] limit;

  // Binary or ASCII form of the name selects one area
  always_comb
  begin
    area_d = req_i.ascii ? ascii_area(req_i.name) : bin_area(req_i.code);
  end

  // Valid runs every cycle so that an idle cycle clears it
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      s1_valid_q <= 1'b0;
    else
      s1_valid_q <= req_valid_i;
  end

  // Payload is taken only with a request and held otherwise
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s1_area_q <= AREA_NONE;
      s1_frame_ok_q <= 1'b0;
      s1_start_q <= 24'h000000;
      s1_points_q <= 16'h0000;
    end
    else if (req_valid_i)
    begin
      s1_area_q <= area_d;
      s1_frame_ok_q <= frame_ok(req_i.frame);
      s1_start_q <= req_i.start;
      s1_points_q <= req_i.points;
    end
  end

  // The table is addressed with this cycle's decode and registers on the
  // same edge as stage 1, so limit belongs to s1_area_q only in the cycle
  // after a request; stage 2 uses it only then
  area_limit_rom u_limit (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .area_i(area_d),
    .adv_sync_i(adv_sync_i),
    .limit_o(limit)
  );

  // ****************************************************************
  // Stage 2: range check and verdict
  // ****************************************************************
  logic range_bad;
  dev_rsp_t rsp_d;
  // Answer register: rsp_valid_q pulses once per request
  dev_rsp_t rsp_q;
  logic rsp_valid_q;

  always_comb
  begin
    range_bad = over_range(s1_start_q, s1_points_q, limit);
    rsp_d.start = s1_start_q;
    rsp_d.points = s1_points_q;
    rsp_d.err = verdict(s1_frame_ok_q, s1_area_q, range_bad);
    rsp_d.ok = (rsp_d.err == ERR_NONE);
    // A refused request names no area, so nothing downstream touches one
    rsp_d.area = rsp_d.ok ? s1_area_q : AREA_NONE;
  end

  // One answer pulse per request, one edge after stage 1 takes it
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rsp_valid_q <= 1'b0;
    else
      rsp_valid_q <= s1_valid_q;
  end

  // The answer holds until the next answer replaces it
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rsp_q <= '0;
    else if (s1_valid_q)
      rsp_q <= rsp_d;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rsp_valid_o = rsp_valid_q;
  assign rsp_o = rsp_q;

endmodule

// file: hw/dev_code_pkg.sv
// Package for the request device-code decoder.
// Assumes one 100 MHz clock and an upstream frame parser supplying requests.
package dev_code_pkg;

  // ****************************************************************
  // Frame and code constants
  // ****************************************************************
  localparam logic [1:0] FRAME_3E = 2'h1;
  localparam logic [7:0] ASCII_SPACE = 8'h20;

  localparam logic [7:0] CODE_SPECIAL_RELAY = 8'h91;
  localparam logic [7:0] CODE_SPECIAL_REGISTER = 8'ha9;
  localparam logic [7:0] CODE_INPUT = 8'h9c;
  localparam logic [7:0] CODE_OUTPUT = 8'h9d;
  localparam logic [7:0] CODE_INTERNAL_RELAY = 8'h90;
  localparam logic [7:0] CODE_ANNUNCIATOR = 8'h93;
  localparam logic [7:0] CODE_LINK_RELAY = 8'ha0;
  localparam logic [7:0] CODE_GENERAL_REGISTER = 8'ha8;
  localparam logic [7:0] CODE_LINK_REGISTER = 8'hb4;
  localparam logic [7:0] CODE_MOTION_REGISTER = 8'he0;

  // ASCII names: first and second characters (second may be a space)
  localparam logic [15:0] ASC_SPECIAL_RELAY = 16'h534d;
  localparam logic [15:0] ASC_SPECIAL_REGISTER = 16'h5344;
  localparam logic [7:0] ASC_INPUT = 8'h58;
  localparam logic [7:0] ASC_OUTPUT = 8'h59;
  localparam logic [7:0] ASC_INTERNAL_RELAY = 8'h4d;
  localparam logic [7:0] ASC_ANNUNCIATOR = 8'h46;
  localparam logic [7:0] ASC_LINK_RELAY = 8'h42;
  localparam logic [7:0] ASC_GENERAL_REGISTER = 8'h44;
  localparam logic [7:0] ASC_LINK_REGISTER = 8'h57;
  localparam logic [7:0] ASC_MOTION_REGISTER = 8'h23;

  // ****************************************************************
  // Area upper limits (last valid number)
  // ****************************************************************
  localparam logic [23:0] MAX_SPECIAL = 24'd2255;
  localparam logic [23:0] MAX_IO = 24'h001fff;
  localparam logic [23:0] MAX_INTERNAL_RELAY = 24'd12287;
  localparam logic [23:0] MAX_ANNUNCIATOR = 24'd2047;
  localparam logic [23:0] MAX_LINK = 24'h001fff;
  localparam logic [23:0] MAX_GENERAL = 24'd8191;
  localparam logic [23:0] MAX_GENERAL_ADV = 24'd19823;
  localparam logic [23:0] MAX_MOTION = 24'd12287;

  // ****************************************************************
  // Error codes
  // ****************************************************************
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_RANGE = 16'hc056;
  localparam logic [15:0] ERR_DEVICE = 16'hc05b;
  localparam logic [15:0] ERR_FRAME = 16'hc059;

  typedef enum logic [3:0] {
    AREA_NONE = 4'h0,
    AREA_SPECIAL_RELAY = 4'h1,
    AREA_SPECIAL_REGISTER = 4'h2,
    AREA_INPUT = 4'h3,
    AREA_OUTPUT = 4'h4,
    AREA_INTERNAL_RELAY = 4'h5,
    AREA_ANNUNCIATOR = 4'h6,
    AREA_LINK_RELAY = 4'h7,
    AREA_GENERAL_REGISTER = 4'h8,
    AREA_LINK_REGISTER = 4'h9,
    AREA_MOTION_REGISTER = 4'ha
  } area_t;

  typedef struct packed {
    logic [1:0] frame;
    logic ascii;
    logic [7:0] code;
    logic [15:0] name;
    logic [23:0] start;
    logic [15:0] points;
  } dev_req_t;

  typedef struct packed {
    area_t area;
    logic [23:0] start;
    logic [15:0] points;
    logic ok;
    logic [15:0] err;
  } dev_rsp_t;

endpackage

// file: hw/area_limit_rom.sv
// Area limit table: maps area to last valid number, registered output.
// Assumes synchronous use from the decoder one cycle ahead of the check.
`timescale 1ns/1ps
module area_limit_rom
  import dev_code_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire area_t area_i,
  input wire logic adv_sync_i,
  output logic [23:0] limit_o
);

  logic [23:0] limit_d;
  logic [23:0] limit_q;

  always_comb
  begin
    limit_d = 24'h000000;
    case (area_i)
      AREA_SPECIAL_RELAY, AREA_SPECIAL_REGISTER: limit_d = MAX_SPECIAL;
      AREA_INPUT, AREA_OUTPUT: limit_d = MAX_IO;
      AREA_INTERNAL_RELAY: limit_d = MAX_INTERNAL_RELAY;
      AREA_ANNUNCIATOR: limit_d = MAX_ANNUNCIATOR;
      AREA_LINK_RELAY, AREA_LINK_REGISTER: limit_d = MAX_LINK;
      AREA_GENERAL_REGISTER: limit_d = adv_sync_i ? MAX_GENERAL_ADV : MAX_GENERAL;
      AREA_MOTION_REGISTER: limit_d = MAX_MOTION;
      default: limit_d = 24'h000000;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      limit_q <= 24'h000000;
    else
      limit_q <= limit_d;
  end

  assign limit_o = limit_q;

endmodule

// file: verification/dev_code_decoder_properties.sv
// Checker for the device-code decoder, watching its ports only.
// Assumes a bind onto device_code_decoder and one clock domain.
`timescale 1ns/1ps
module dev_code_decoder_properties
  import dev_code_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic req_valid_i,
  input wire dev_req_t req_i,
  input wire logic adv_sync_i,
  input wire logic rsp_valid_o,
  input wire dev_rsp_t rsp_o
);
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  logic bin;
  logic [24:0] fin;
  assign bin = req_valid_i && req_i.frame == FRAME_3E && !req_i.ascii;
  assign fin = {1'b0, req_i.start} + {9'h000, req_i.points};
  a_answer_latency: assert property (req_valid_i |-> ##2 rsp_valid_o)
    else $error("answer not two cycles after request");
  a_no_stray: assert property (rsp_valid_o |-> $past(req_valid_i, 2))
    else $error("answer without request");
  a_input_area: assert property (bin && req_i.code == CODE_INPUT && fin <= MAX_IO + 1
    |-> ##2 rsp_o.area == AREA_INPUT) else $error("input code not decoded");
  a_output_area: assert property (bin && req_i.code == CODE_OUTPUT && fin <= MAX_IO + 1
    |-> ##2 rsp_o.area == AREA_OUTPUT) else $error("output code not decoded");
  a_general_ext: assert property (bin && req_i.code == CODE_GENERAL_REGISTER && adv_sync_i
    && fin == MAX_GENERAL_ADV + 1 |-> ##2 rsp_o.ok) else $error("extended range refused");
  a_frame_refused: assert property (req_valid_i && req_i.frame != FRAME_3E
    |-> ##2 rsp_o.err == ERR_FRAME) else $error("wrong frame accepted");
  a_motion_area: assert property (bin && req_i.code == CODE_MOTION_REGISTER && fin <= MAX_MOTION + 1
    |-> ##2 rsp_o.area == AREA_MOTION_REGISTER) else $error("motion code not decoded");
  a_relay_range: assert property (bin && req_i.code == CODE_INTERNAL_RELAY
    && fin > MAX_INTERNAL_RELAY + 1 |-> ##2 rsp_o.err == ERR_RANGE) else $error("range not refused");
  a_unknown_code: assert property (bin && req_i.code == 8'h00
    |-> ##2 !rsp_o.ok && rsp_o.area == AREA_NONE) else $error("unknown code accepted");
endmodule
bind device_code_decoder dev_code_decoder_properties i_props (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
  .req_valid_i(req_valid_i), .req_i(req_i), .adv_sync_i(adv_sync_i), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o));

// file: verification/host_model.sv
// Host model: issues parsed requests as one-cycle strobes.
// Assumes calls only after reset release.
`timescale 1ns/1ps
module host_model
  import dev_code_pkg::*;
(
  input wire logic ref_clk_i,
  output logic req_valid_o,
  output dev_req_t req_o
);
  initial
  begin
    req_valid_o = 1'b0;
    req_o = '0;
  end
  task automatic send(input dev_req_t r);
    @(posedge ref_clk_i);
    #1;
    req_valid_o = 1'b1;
    req_o = r;
  endtask
  // Released request lines show the inverse of the last value
  task automatic idle();
    @(posedge ref_clk_i);
    #1;
    req_valid_o = 1'b0;
    req_o = ~req_o;
  endtask
endmodule

// file: verification/tb_device_code_decoder.sv
// Bench for the device-code decoder with host model and queue scoreboard.
// Assumes the package constants and a two-cycle answer.
`timescale 1ns/1ps
module tb_device_code_decoder;
  import dev_code_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic adv_sync_i = 1'b0;
  logic adv_next = 1'b0;
  logic req_valid_i;
  dev_req_t req_i;
  logic rsp_valid_o;
  dev_rsp_t rsp_o;
  dev_rsp_t e;
  dev_rsp_t exp_q[$];
  int n_fail = 0;
  int checks_done = 0;
  logic [7:0] codes [10] = '{CODE_SPECIAL_RELAY, CODE_SPECIAL_REGISTER, CODE_INPUT, CODE_OUTPUT,
    CODE_INTERNAL_RELAY, CODE_ANNUNCIATOR, CODE_LINK_RELAY, CODE_GENERAL_REGISTER, CODE_LINK_REGISTER,
    CODE_MOTION_REGISTER};
  logic [15:0] names [10] = '{ASC_SPECIAL_RELAY, ASC_SPECIAL_REGISTER, {ASC_INPUT, ASCII_SPACE},
    {ASC_OUTPUT, ASCII_SPACE}, {ASC_INTERNAL_RELAY, ASCII_SPACE}, {ASC_ANNUNCIATOR, ASCII_SPACE},
    {ASC_LINK_RELAY, ASCII_SPACE}, {ASC_GENERAL_REGISTER, ASCII_SPACE}, {ASC_LINK_REGISTER, ASCII_SPACE},
    {ASC_MOTION_REGISTER, ASCII_SPACE}};
  logic [23:0] limits [10] = '{MAX_SPECIAL, MAX_SPECIAL, MAX_IO, MAX_IO, MAX_INTERNAL_RELAY,
    MAX_ANNUNCIATOR, MAX_LINK, MAX_GENERAL, MAX_LINK, MAX_MOTION};
  always #5 ref_clk_i = ~ref_clk_i;
  host_model i_host (.ref_clk_i(ref_clk_i), .req_valid_o(req_valid_i), .req_o(req_i));
  device_code_decoder i_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .adv_sync_i(adv_sync_i), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o));
  function automatic dev_rsp_t expect_rsp(dev_req_t r, logic adv);
    dev_rsp_t x;
    logic [24:0] lim;
    x = '0;
    x.start = r.start;
    x.points = r.points;
    x.err = ERR_DEVICE;
    for (int i = 0; i < 10; i++)
      if (r.ascii ? r.name === names[i] : r.code === codes[i])
      begin
        lim = (i == 7 && adv) ? {1'b0, MAX_GENERAL_ADV} : {1'b0, limits[i]};
        x.err = ({1'b0, r.start} + r.points > lim + 1) ? ERR_RANGE : ERR_NONE;
        x.area = (x.err === ERR_NONE) ? area_t'(i + 1) : AREA_NONE;
      end
    if (r.frame !== FRAME_3E)
      x.err = ERR_FRAME;
    x.ok = (x.err === ERR_NONE);
    x.area = x.ok ? x.area : AREA_NONE;
    return x;
  endfunction
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] want);
    checks_done++;
    if (seen !== want)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic put(input logic [1:0] f, input logic a, input logic [7:0] c, input logic [15:0] n,
    input logic [23:0] s, input logic [15:0] p);
    dev_req_t r;
    r = '{f, a, c, n, s, p};
    exp_q.push_back(expect_rsp(r, adv_next));
    i_host.send(r);
    // The mode level changes together with the request it belongs to
    adv_sync_i = adv_next;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic drain(input string name);
    i_host.idle();
    for (int k = 0; k < 20 && exp_q.size() != 0; k++)
      @(posedge ref_clk_i);
    if (exp_q.size() != 0)
    begin
      n_fail++;
      report_and_stop();
    end
    else
      $display("test %s done", name);
  endtask
  always @(negedge ref_clk_i)
    if (rsp_valid_o === 1'b1)
    begin
      e = exp_q.size() ? exp_q.pop_front() : ~'0;
      check("area", rsp_o.area, e.area);
      check("ok", rsp_o.ok, e.ok);
      check("err", rsp_o.err, e.err);
      check("start", rsp_o.start, e.start);
      check("points", rsp_o.points, e.points);
    end
  initial
  begin
    void'($urandom(38));
    repeat (12) @(posedge ref_clk_i);
    #1;
    rst_b_i = 1'b1;
    // ****
    // Boundary of every area, back to back
    // ****
    for (int i = 0; i < 10; i++)
      for (int p = 1; p < 3; p++)
        put(FRAME_3E, 1'b0, codes[i], 16'h0000, limits[i], p[15:0]);
    adv_next = 1'b1;
    put(FRAME_3E, 1'b0, CODE_GENERAL_REGISTER, 16'h0000, MAX_GENERAL_ADV, 16'h0001);
    put(FRAME_3E, 1'b0, CODE_GENERAL_REGISTER, 16'h0000, MAX_GENERAL_ADV, 16'h0002);
    drain("limits");
    adv_next = 1'b0;
    for (int i = 0; i < 10; i++)
      put(FRAME_3E, 1'b1, 8'h00, names[i], 24'h000000, 16'h0001);
    drain("ascii");
    for (int f = 0; f < 4; f++)
      put(f[1:0], 1'b0, CODE_INPUT, 16'h0000, 24'h000000, 16'h0001);
    put(FRAME_3E, 1'b0, 8'h00, 16'h0000, 24'h000000, 16'h0001);
    put(FRAME_3E, 1'b0, 8'hff, 16'h0000, 24'h000000, 16'h0001);
    drain("refusals");
    for (int k = 0; k < 200; k++)
    begin
      int i;
      i = $urandom % 10;
      adv_next = 1'($urandom);
      put(FRAME_3E, 1'b0, codes[i], 16'h0000, 24'($urandom % (limits[i] + 2)), 16'($urandom % 64));
    end
    drain("random");
    report_and_stop();
  end
endmodule
